// ==== include/esr_regs.svh ====
`ifndef ESR_REGS_SVH
`define ESR_REGS_SVH

// Register addresses on the plain register port
`define ESR_ADDR_RX_CTRL      4'h0
`define ESR_ADDR_BAUD_CTRL    4'h1
`define ESR_ADDR_DIV_LO       4'h2
`define ESR_ADDR_DIV_HI       4'h3
`define ESR_ADDR_RX_BUF       4'h4
`define ESR_ADDR_MODE_CTRL    4'h5
`define ESR_ADDR_AUTO_BAUD    4'h6

// Receive status and control bits
`define ESR_RC_PORT_EN        7
`define ESR_RC_NINE_BIT       6
`define ESR_RC_SINGLE         5
`define ESR_RC_CONT           4
`define ESR_RC_ADDR_DET       3
`define ESR_RC_FRAME_ERR      2
`define ESR_RC_OVERRUN        1
`define ESR_RC_NINTH          0

// Baud rate control bits
`define ESR_BC_IDLE           6
`define ESR_BC_POLARITY       4
`define ESR_BC_WIDE           3
`define ESR_BC_WAKE           1
`define ESR_BC_AUTO_BAUD      0

// Mode control bits (local register)
`define ESR_MC_CLK_SRC        7
`define ESR_MC_SYNC           4
`define ESR_MC_HIGH_SPEED     2

// Reset values
`define ESR_RST_RX_CTRL       8'h00
`define ESR_RST_BAUD_CTRL     8'h40
`define ESR_RST_DIV           8'h00
`define ESR_RST_MODE_CTRL     8'h00

// Baud timer prescale per divisor step
`define ESR_PRE_ASYNC_SLOW8   7'h40
`define ESR_PRE_ASYNC_MID     7'h10
`define ESR_PRE_ASYNC_FAST16  7'h04
`define ESR_PRE_SYNC          7'h04

// Ticks per bit and sample points within a bit
`define ESR_TICKS_PER_BIT     4'h4
`define ESR_SAMPLE_A          4'h1
`define ESR_SAMPLE_B          4'h2
`define ESR_SAMPLE_C          4'h3
`define ESR_LAST_BIT_ASYNC    4'h9
`define ESR_SYNC_PATTERN      8'h55
`define ESR_AB_EDGES          3'h5

`endif

// ==== include/esr_pkg.sv ====
package esr_pkg;
    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } esr_bus_req_type;

    // Pin group: outputs and output enables of both serial pins
    typedef struct packed {
        logic data_o;
        logic data_oe;
        logic clk_o;
        logic clk_oe;
    } esr_pin_out_type;

    typedef enum logic [1:0] {
        ESR_IDLE,
        ESR_START,
        ESR_DATA,
        ESR_STOP
    } esr_rx_state_type;
endpackage

// ==== rtl/esr_receiver.sv ====
// Summary of operation
// [RL1] Port enable drives pins; clear holds reset (wake detection and wake clear still run with it clear)
// [RL2] Nine-bit select picks nine or eight bits
// [RL3] Single receive in sync master, self-clearing
// [RL4] Continuous receive enables, overrides single
// [RL5] Address detect keeps only ninth-bit-one characters
// [RL6] Read-only framing error per character
// [RL7] Overrun flag cleared by clearing continuous
// [RL8] Ninth received bit readable, no parity
// [RL9] Idle status one when not receiving
// [RL10] Clock polarity sets sync clock idle
// [RL11] Wide select uses both divisor bytes
// [RL12] Wake on falling edge, cleared rising
// [RL13] Auto-baud measures sync character, self-clears
// [RL14] Divisor sets free-running baud timer
// [RL15] Async 8-bit slow: osc/64(n+1)
// [RL16] Async 16-bit slow: osc/16(n+1)
// [RL17] Sync: osc/4(n+1)
// [RL18] Formulas only for internal clock
// [RL19] Divisor write clears baud timer
// [RL20] Three samples, majority vote per bit; vote uses the bit's first two samples and the previous bit's third
// [RL21] Mode select: sync set, async clear
// [RL22] Clock source: master set, slave clear
// [RL23] Async fast: /16 8-bit, /4 16-bit
// [RL24] Start, data LSB first, high stop
`timescale 1ns/100ps
`include "esr_regs.svh"

module esr_receiver #(
    parameter int DIV_W = 16
) (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire esr_pkg::esr_bus_req_type bus_req,
    output logic [7:0]                    rdata,
    input  wire logic                     data_i,
    input  wire logic                     clk_i,
    output esr_pkg::esr_pin_out_type      pins,
    output logic                          rx_irq,
    output logic                          wake_irq
);
    import esr_pkg::*;

    logic [7:0]        rc_q;
    logic [7:3]        rc_ctl_q;
    logic [2:0]        rc_sts_q;
    logic [7:0]        bc_q;
    logic [7:0]        mc_q;
    logic [7:0]        div_lo_q;
    logic [7:0]        div_hi_q;
    logic [7:0]        buf_q;
    logic              buf_full_q;
    logic [DIV_W-1:0]  ab_val_q;
    logic [DIV_W-1:0]  brg_q;
    logic [6:0]        pre_q;
    logic [3:0]        tick_q;
    logic [3:0]        bit_q;
    logic [8:0]        shift_q;
    logic [2:0]        samp_q;
    logic              rx_prev_q;
    logic              sclk_q;
    logic              sclk_prev_q;
    esr_rx_state_type  state_q;
    logic [DIV_W-1:0]  ab_cnt_q;
    logic [2:0]        ab_edges_q;
    logic              ab_run_q;
    logic [7:0]        rdata_q;

    logic              port_en;
    logic              sync_mode;
    logic              master;
    logic              wide;
    logic              nine;
    logic [6:0]        prescale;
    logic [DIV_W-1:0]  divisor;
    logic              baud_tick;
    logic              wr_div;
    logic              rx_en;
    logic              majority;
    logic              char_done;
    logic              accept;
    logic              buf_rd;
    logic              sync_bit_edge;
    logic              rx_fall;
    logic              rx_rise;

    // Majority of three samples
    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Register-port write decode
    function automatic logic wr_hit(input esr_bus_req_type r, input logic [3:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    // Mode decode
    assign rc_q      = {rc_ctl_q, rc_sts_q};
    assign port_en   = rc_q[`ESR_RC_PORT_EN];
    assign sync_mode = mc_q[`ESR_MC_SYNC];                          // RL21
    assign master    = sync_mode && mc_q[`ESR_MC_CLK_SRC];          // RL22
    assign wide      = bc_q[`ESR_BC_WIDE];
    assign nine      = rc_q[`ESR_RC_NINE_BIT];                      // RL2
    assign divisor   = wide ? DIV_W'({div_hi_q, div_lo_q})          // RL11
                            : DIV_W'(div_lo_q);
    assign wr_div    = wr_hit(bus_req, `ESR_ADDR_DIV_LO) ||
                       wr_hit(bus_req, `ESR_ADDR_DIV_HI);
    assign buf_rd    = bus_req.rd && (bus_req.addr == `ESR_ADDR_RX_BUF);
    // Receiver enable: continuous wins, single only in sync master
    assign rx_en     = port_en && (rc_q[`ESR_RC_CONT] ||            // RL4
                       (master && rc_q[`ESR_RC_SINGLE]));           // RL3

    // Prescale per divisor step, chosen so four ticks make one async bit
    always_comb begin
        if (sync_mode) begin
            prescale = `ESR_PRE_SYNC;                               // RL17 RL14
        end else if (!mc_q[`ESR_MC_HIGH_SPEED]) begin
            prescale = wide ? `ESR_PRE_ASYNC_MID                    // RL16
                            : `ESR_PRE_ASYNC_SLOW8;                 // RL15
        end else begin
            prescale = wide ? `ESR_PRE_ASYNC_FAST16                 // RL23
                            : `ESR_PRE_ASYNC_MID;                   // RL23
        end
    end

    // Free-running baud timer; async: a quarter-bit tick per (n+1)*prescale/4
    logic [6:0] pre_top;
    // Sync: one tick per clock half, so one bit takes prescale*(n+1) clocks
    assign pre_top   = sync_mode ? ((prescale >> 1) - 7'h01)        // RL17
                                 : ((prescale >> 2) - 7'h01);
    assign baud_tick = (pre_q == pre_top) && (brg_q == divisor);
    always_ff @(posedge clk) begin
        if (reset || !port_en || wr_div) begin                      // RL19 RL1
            pre_q <= 7'h00;
            brg_q <= '0;
        end else if (pre_q == pre_top) begin
            pre_q <= 7'h00;
            brg_q <= (brg_q == divisor) ? '0 : brg_q + 1'b1;        // RL14
        end else begin
            pre_q <= pre_q + 7'h01;
        end
    end

    // Receive pin history and edges
    assign rx_fall = rx_prev_q && !data_i;
    assign rx_rise = !rx_prev_q && data_i;
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            rx_prev_q   <= data_i;
            sclk_prev_q <= clk_i;
        end
    end

    // Sync clock: master toggles per tick; a started pulse finishes even after the receiver stops
    always_ff @(posedge clk) begin
        if (reset || !port_en) begin
            sclk_q <= 1'b0;
        end else if (master && baud_tick && (state_q != ESR_IDLE || sclk_q)) begin
            sclk_q <= !sclk_q;                                      // RL18
        end
    end
    // Data sampled on the master clock's leading edge away from idle; slave samples on clk_i rising
    assign sync_bit_edge = master ? (baud_tick && !sclk_q)
                                  : (!sclk_prev_q && clk_i);        // RL18

    // Serial pins: data input only; clock driven in sync master
    always_comb begin
        pins.data_o  = 1'b0;
        pins.data_oe = 1'b0;
        pins.clk_o   = sclk_q ^ bc_q[`ESR_BC_POLARITY];             // RL10
        pins.clk_oe  = port_en && master;                           // RL1
    end

    // Majority sampler: three samples per bit
    assign majority = vote3(samp_q);                                // RL20
    always_ff @(posedge clk) begin
        if (reset || state_q == ESR_IDLE) begin
            samp_q <= 3'h7;
        end else if (baud_tick && (tick_q == `ESR_SAMPLE_A ||
                     tick_q == `ESR_SAMPLE_B || tick_q == `ESR_SAMPLE_C)) begin
            samp_q <= {samp_q[1:0], data_i};                        // RL20
        end
    end

    // Receive state machine
    logic bit_end;
    assign bit_end   = baud_tick && (tick_q == `ESR_TICKS_PER_BIT - 4'h1);
    assign char_done = sync_mode
        ? (state_q == ESR_DATA && sync_bit_edge && bit_q == (nine ? 4'h8 : 4'h7))
        : (state_q == ESR_STOP && bit_end);
    always_ff @(posedge clk) begin
        if (reset || !port_en || !rx_en) begin                      // RL1
            state_q <= ESR_IDLE;
            tick_q  <= 4'h0;
            bit_q   <= 4'h0;
            shift_q <= 9'h000;
        end else begin
            unique case (state_q)
                ESR_IDLE: begin
                    tick_q <= 4'h0;
                    bit_q  <= 4'h0;
                    if (sync_mode) begin
                        state_q <= ESR_DATA;
                    end else if (rx_fall && !bc_q[`ESR_BC_WAKE] &&
                                 !bc_q[`ESR_BC_AUTO_BAUD]) begin    // RL13
                        state_q <= ESR_START;                       // RL24
                    end
                end
                ESR_START: begin
                    if (baud_tick) begin
                        tick_q <= tick_q + 4'h1;
                    end
                    if (bit_end) begin
                        tick_q  <= 4'h0;
                        state_q <= majority ? ESR_IDLE : ESR_DATA;  // RL24
                    end
                end
                ESR_DATA: begin
                    if (sync_mode) begin
                        if (sync_bit_edge) begin
                            shift_q <= nine ? {data_i, shift_q[8:1]}
                                            : {1'b0, data_i, shift_q[7:1]};
                            bit_q   <= bit_q + 4'h1;
                            if (char_done) begin
                                state_q <= ESR_IDLE;
                            end
                        end
                    end else begin
                        if (baud_tick) begin
                            tick_q <= tick_q + 4'h1;
                        end
                        if (bit_end) begin
                            tick_q  <= 4'h0;
                            // LSB first into the top, shifting down
                            shift_q <= nine ? {majority, shift_q[8:1]}
                                            : {1'b0, majority, shift_q[7:1]}; // RL24
                            bit_q   <= bit_q + 4'h1;
                            if (bit_q == (nine ? 4'h8 : 4'h7)) begin // RL2
                                state_q <= ESR_STOP;
                            end
                        end
                    end
                end
                ESR_STOP: begin
                    if (baud_tick) begin
                        tick_q <= tick_q + 4'h1;
                    end
                    if (bit_end) begin
                        state_q <= ESR_IDLE;
                    end
                end
            endcase
        end
    end

    // Address filter in async nine-bit mode
    logic [8:0] final_word;
    assign final_word = sync_mode
        ? (nine ? {data_i, shift_q[8:1]} : {1'b0, data_i, shift_q[7:1]})
        : shift_q;
    assign accept = char_done && (sync_mode || !nine ||
                    !rc_q[`ESR_RC_ADDR_DET] || final_word[8]) &&    // RL5
                    !ab_run_q && !bc_q[`ESR_BC_AUTO_BAUD];

    // Receive buffer, overrun, framing and ninth bit
    always_ff @(posedge clk) begin
        if (reset || !port_en) begin                                // RL1
            buf_q      <= 8'h00;
            buf_full_q <= 1'b0;
            rc_sts_q   <= 3'h0;
        end else begin
            if (buf_rd) begin
                buf_full_q <= 1'b0;
            end
            if (!rc_q[`ESR_RC_CONT]) begin
                rc_sts_q[`ESR_RC_OVERRUN] <= 1'b0;                  // RL7
            end
            if (accept && buf_full_q && !buf_rd) begin
                rc_sts_q[`ESR_RC_OVERRUN] <= 1'b1;                  // RL7
            end else if (accept) begin
                buf_q      <= final_word[7:0];
                buf_full_q <= 1'b1;                                 // RL5
                rc_sts_q[`ESR_RC_NINTH]     <= final_word[8];       // RL8
                rc_sts_q[`ESR_RC_FRAME_ERR] <= !sync_mode && !majority; // RL6 RL24
            end
        end
    end
    assign rx_irq = buf_full_q;                                     // RL5

    // Control bits of receive register, with hardware clear of single
    always_ff @(posedge clk) begin
        if (reset) begin
            rc_ctl_q <= 5'(`ESR_RST_RX_CTRL >> 3);
        end else if (wr_hit(bus_req, `ESR_ADDR_RX_CTRL)) begin
            rc_ctl_q <= bus_req.wdata[7:3];
        end else if (char_done && master && !rc_q[`ESR_RC_CONT]) begin
            rc_ctl_q[`ESR_RC_SINGLE] <= 1'b0;                       // RL3
        end
    end

    // Mode and divisor registers
    always_ff @(posedge clk) begin
        if (reset) begin
            mc_q     <= `ESR_RST_MODE_CTRL;
            div_lo_q <= `ESR_RST_DIV;
            div_hi_q <= `ESR_RST_DIV;
        end else begin
            if (wr_hit(bus_req, `ESR_ADDR_MODE_CTRL)) begin
                mc_q <= bus_req.wdata;
            end
            if (wr_hit(bus_req, `ESR_ADDR_DIV_LO)) begin
                div_lo_q <= bus_req.wdata;
            end
            if (wr_hit(bus_req, `ESR_ADDR_DIV_HI)) begin
                div_hi_q <= bus_req.wdata;
            end
        end
    end

    // Baud control: software bits, hardware clears of wake and auto-baud
    logic ab_done;
    assign wake_irq = !sync_mode && bc_q[`ESR_BC_WAKE] && rx_fall; // RL12
    always_ff @(posedge clk) begin
        if (reset) begin
            bc_q <= `ESR_RST_BAUD_CTRL;
        end else begin
            if (wr_hit(bus_req, `ESR_ADDR_BAUD_CTRL)) begin
                bc_q[`ESR_BC_POLARITY]  <= bus_req.wdata[`ESR_BC_POLARITY];
                bc_q[`ESR_BC_WIDE]      <= bus_req.wdata[`ESR_BC_WIDE];
                bc_q[`ESR_BC_WAKE]      <= bus_req.wdata[`ESR_BC_WAKE];
                bc_q[`ESR_BC_AUTO_BAUD] <= bus_req.wdata[`ESR_BC_AUTO_BAUD];
            end
            if (!sync_mode && bc_q[`ESR_BC_WAKE] && rx_rise) begin
                bc_q[`ESR_BC_WAKE] <= 1'b0;                         // RL12
            end
            if (ab_done) begin
                bc_q[`ESR_BC_AUTO_BAUD] <= 1'b0;                    // RL13
            end
            bc_q[`ESR_BC_IDLE] <= (state_q == ESR_IDLE) ||
                                  (sync_mode && !rx_en);            // RL9
        end
    end

    // Auto-baud: time from start edge across sync character falling edges
    // Sync character has five falling edges, start edge included
    assign ab_done = ab_run_q && rx_fall && ab_edges_q == `ESR_AB_EDGES - 3'h2;
    always_ff @(posedge clk) begin
        if (reset || !port_en || sync_mode) begin
            ab_run_q   <= 1'b0;
            ab_cnt_q   <= '0;
            ab_edges_q <= 3'h0;
            ab_val_q   <= '0;
        end else if (!ab_run_q) begin
            ab_cnt_q   <= '0;
            ab_edges_q <= 3'h0;
            if (bc_q[`ESR_BC_AUTO_BAUD] && rx_fall && !bc_q[`ESR_BC_WAKE]) begin
                ab_run_q <= 1'b1;                                   // RL13
            end
        end else begin
            ab_cnt_q <= ab_cnt_q + 1'b1;
            if (rx_fall) begin
                ab_edges_q <= ab_edges_q + 3'h1;
            end
            if (ab_done) begin
                ab_run_q <= 1'b0;
                ab_val_q <= ab_cnt_q;                               // RL13
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                `ESR_ADDR_RX_CTRL:   rdata_q <= rc_q;
                `ESR_ADDR_BAUD_CTRL: rdata_q <= bc_q & 8'h5b;
                `ESR_ADDR_DIV_LO:    rdata_q <= div_lo_q;
                `ESR_ADDR_DIV_HI:    rdata_q <= div_hi_q;
                `ESR_ADDR_RX_BUF:    rdata_q <= buf_q;
                `ESR_ADDR_MODE_CTRL: rdata_q <= mc_q;
                `ESR_ADDR_AUTO_BAUD: rdata_q <= ab_val_q[7:0];
                default:             rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;
endmodule

// ==== verif/esr_receiver_chk.sv ====
`timescale 1ns/100ps
module esr_receiver_chk
    import esr_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire esr_pkg::esr_bus_req_type bus_req,
    input wire logic [7:0]               rdata,
    input wire logic                     data_i,
    input wire logic                     clk_i,
    input wire esr_pkg::esr_pin_out_type pins,
    input wire logic                     rx_irq,
    input wire logic                     wake_irq
);
    logic [7:0]  rc_q, bc_q, mc_q, lo_q, hi_q;
    logic [15:0] div;
    logic [16:0] cnt_q;

    // Divisor as software set it, wide or low byte only
    assign div = bc_q[3] ? {hi_q, lo_q} : {8'h00, lo_q};

    // Shadow copies of what software wrote
    always_ff @(posedge clk) begin
        if (reset) begin
            rc_q <= 8'h00;
            bc_q <= 8'h00;
            mc_q <= 8'h00;
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                4'h0: rc_q <= bus_req.wdata;
                4'h1: bc_q <= bus_req.wdata;
                4'h2: lo_q <= bus_req.wdata;
                4'h3: hi_q <= bus_req.wdata;
                4'h5: mc_q <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // Cycles since the master clock last changed, saturating
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= 17'h00000;
        end else if ($changed(pins.clk_o)) begin
            cnt_q <= 17'h00001;
        end else if (cnt_q != 17'h1ffff) begin
            cnt_q <= cnt_q + 17'h00001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_CLK_OE: assert property (pins.clk_oe == (rc_q[7] && mc_q[7] && mc_q[4]))
        else $error("clock enable does not match mode");
    AST_CLK_IDLE: assert property ((pins.clk_oe && rc_q[5:4] == 2'b00) |->
        pins.clk_o == bc_q[4]) else $error("clock idle level wrong");
    AST_DATA_OFF: assert property (!pins.data_oe && !pins.data_o)
        else $error("data pin driven");
    AST_WAKE_CAUSE: assert property (wake_irq |-> bc_q[1] && !mc_q[4])
        else $error("wake pulse without wake enable");
    AST_WAKE_PULSE: assert property (wake_irq |=> !wake_irq)
        else $error("wake pulse longer than one cycle");
    AST_READ_CLR: assert property ((bus_req.rd && bus_req.addr == 4'h4 && rx_irq) |=>
        !rx_irq) else $error("receive flag kept after buffer read");
    AST_OFF_QUIET: assert property ((!rc_q[7] && !$past(rc_q[7])) |->
        !rx_irq && !pins.clk_oe) else $error("activity with port disabled");
    AST_RX_NEEDS_EN: assert property ($rose(rx_irq) |-> rc_q[4] || rc_q[5])
        else $error("character received with receiver off");
    AST_CLK_RATE: assert property (($changed(pins.clk_o) && pins.clk_oe && $past(pins.clk_oe)
        && !$past(bus_req.wr)) |-> cnt_q >= {div, 1'b0} + 17'h00002)
        else $error("master clock half period too short");

    COV_RX: cover property ($rose(rx_irq));
    COV_WAKE: cover property (wake_irq);
    COV_SYNC_CLK: cover property ($changed(pins.clk_o) && pins.clk_oe);
endmodule

bind esr_receiver esr_receiver_chk #(.DIV_W(DIV_W)) u_chk (
    .clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata), .data_i(data_i),
    .clk_i(clk_i), .pins(pins), .rx_irq(rx_irq), .wake_irq(wake_irq));

// ==== verif/esr_remote.sv ====
`timescale 1ns/100ps
module esr_remote (
    input  wire logic clk,
    output logic      line,
    output logic      sclk,
    input  wire logic ser_clk,
    input  wire logic idle_lvl
);
    logic [7:0] sh_q;
    logic       prev_q;

    // Line idles high, external clock stands still
    initial begin
        line = 1'b1;
        sclk = 1'b0;
        sh_q = 8'hff;
        prev_q = 1'b0;
    end

    // Async character: idle gap, low start, LSB first, chosen stop level
    task automatic send(input logic [8:0] val, input int nbits, input int per, input logic stop);
        repeat (2 * per) @(posedge clk);
        line <= 1'b0;
        repeat (per) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            line <= val[i];
            repeat (per) @(posedge clk);
        end
        line <= stop;
        repeat (per) @(posedge clk);
        line <= 1'b1;
    endtask

    // Low pulse for the wake detector
    task automatic low(input int n);
        line <= 1'b0;
        repeat (n) @(posedge clk);
        line <= 1'b1;
    endtask

    // Preload a synchronous character, first bit on the line
    task automatic load(input logic [7:0] v);
        sh_q <= v;
        line <= v[0];
    endtask

    // Next bit is shifted out when the master clock returns to idle
    always @(posedge clk) begin
        prev_q <= ser_clk;
        if (ser_clk === idle_lvl && prev_q !== idle_lvl) begin
            line <= sh_q[1];
            sh_q <= {1'b1, sh_q[7:1]};
        end
    end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/100ps
module tb;
    import esr_pkg::*;
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    esr_bus_req_type req = '0;
    logic [7:0]      rdata;
    logic            data_i;
    logic            clk_i;
    logic            idle_lvl = 1'b0;
    esr_pin_out_type pins;
    logic            rx_irq;
    logic            wake_irq;
    int              mismatches = 0;
    int              checks = 0;
    int              wakes = 0;

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    esr_receiver #(.DIV_W(16)) dut (
        .clk(clk), .reset(reset), .bus_req(req), .rdata(rdata), .data_i(data_i),
        .clk_i(clk_i), .pins(pins), .rx_irq(rx_irq), .wake_irq(wake_irq));

    esr_remote partner (
        .clk(clk), .line(data_i), .sclk(clk_i), .ser_clk(pins.clk_o), .idle_lvl(idle_lvl));

    // Count wake pulses
    always @(posedge clk) begin
        if (wake_irq === 1'b1) wakes++;
    end

    task automatic conclude();
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        check("rdata", rdata, exp);
    endtask

    task automatic await_irq(input logic exp);
        for (int i = 0; i < 200 && rx_irq !== 1'b1; i++) @(posedge clk);
        #1;
        check("rx_irq", {7'h00, rx_irq}, {7'h00, exp});
    endtask

    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        conclude();
    end

    // Test sequence
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h40);
        rd(4'h2, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h5, 8'h00);
        wr(4'h7, 8'hff);
        rd(4'h7, 8'h00);
        wr(4'h1, 8'h18);
        rd(4'h1, 8'h58);
        wr(4'h1, 8'h08);
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h90);
        fork
            partner.send(9'h0a5, 8, 32, 1'b1);
            begin
                repeat (120) @(posedge clk);
                rd(4'h1, 8'h08);
            end
        join
        await_irq(1'b1);
        rd(4'h0, 8'h90);
        rd(4'h4, 8'ha5);
        rd(4'h1, 8'h48);
        partner.send(9'h03c, 8, 32, 1'b0);
        await_irq(1'b1);
        rd(4'h0, 8'h94);
        rd(4'h4, 8'h3c);
        partner.send(9'h069, 8, 32, 1'b1);
        partner.send(9'h096, 8, 32, 1'b1);
        rd(4'h0, 8'h92);
        rd(4'h4, 8'h69);
        wr(4'h0, 8'h80);
        rd(4'h0, 8'h80);
        wr(4'h0, 8'hd8);
        partner.send(9'h011, 9, 32, 1'b1);
        await_irq(1'b0);
        partner.send(9'h122, 9, 32, 1'b1);
        await_irq(1'b1);
        rd(4'h0, 8'hd9);
        rd(4'h4, 8'h22);
        wr(4'h0, 8'hd0);
        partner.send(9'h033, 9, 32, 1'b1);
        await_irq(1'b1);
        rd(4'h0, 8'hd0);
        rd(4'h4, 8'h33);
        wr(4'h1, 8'h00);
        wr(4'h3, 8'h05);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h90);
        partner.send(9'h05a, 8, 64, 1'b1);
        await_irq(1'b1);
        rd(4'h4, 8'h5a);
        wr(4'h0, 8'h80);
        wr(4'h1, 8'h02);
        partner.low(40);
        repeat (8) @(posedge clk);
        rd(4'h1, 8'h40);
        check("wakes", 8'(wakes), 8'h01);
        wr(4'h1, 8'h09);
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h01);
        wr(4'h0, 8'h90);
        partner.send(9'h055, 8, 32, 1'b1);
        await_irq(1'b0);
        rd(4'h1, 8'h48);
        wr(4'h0, 8'h80);
        wr(4'h5, 8'h90);
        wr(4'h1, 8'h10);
        #1;
        check("clk_o", {7'h00, pins.clk_o}, 8'h01);
        check("clk_oe", {7'h00, pins.clk_oe}, 8'h01);
        wr(4'h1, 8'h00);
        #1;
        check("clk_o", {7'h00, pins.clk_o}, 8'h00);
        repeat (2) @(posedge clk);
        partner.load(8'hc3);
        wr(4'h0, 8'ha0);
        await_irq(1'b1);
        rd(4'h4, 8'hc3);
        rd(4'h0, 8'h80);
        wr(4'h0, 8'h00);
        @(posedge clk);
        #1;
        check("clk_oe", {7'h00, pins.clk_oe}, 8'h00);
        conclude();
    end
endmodule
